// ==== verilog/pldl_port_ctrl.sv ====
// per-port link resolution, cable test and led driver
module pldl_port_ctrl #(
  parameter int BLINK_COUNT = pldl_pkg::BLINK_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire pldl_pkg::pldl_line_t line_in,
  input wire logic activity,
  input wire logic [7:0] line_rx_data,
  output logic [7:0] line_tx_data,
  output logic loopback_active,
  output logic probe_start,
  output logic [1:0] probe_pair,
  output logic link_up,
  output logic [1:0] link_speed,
  output logic link_full_duplex,
  output logic link_indicator_pin,
  output logic activity_indicator_pin
);
  pldl_pkg::pldl_state_reg_t s_reg;
  pldl_pkg::pldl_state_reg_t s_next;

  logic [15:0] wmask;
  logic [15:0] wval;
  logic [15:0] common;
  logic gig_common_full;
  logic gig_common_half;
  logic [1:0] forced_code;

  // byte enables into a 16-bit write mask
  assign wmask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
  // read answers one cycle after the request
  assign waitrequest = read & ~s_reg.rvalid;
  assign readdata = s_reg.rdata;
  assign line_tx_data = s_reg.loopback[pldl_pkg::LB_ENABLE] ?
                        line_rx_data : 8'h00;
  assign loopback_active = s_reg.loopback[pldl_pkg::LB_ENABLE]
                           & s_reg.full_duplex;
  assign probe_start = s_reg.state == pldl_pkg::PLDL_DIAG;
  assign probe_pair = s_reg.diag[13:12];
  assign link_up = s_reg.link_up;
  assign link_speed = s_reg.speed;
  assign link_full_duplex = s_reg.full_duplex;
  assign link_indicator_pin = s_reg.link_led_n;
  assign activity_indicator_pin = s_reg.act_led_n;

  // shared abilities between own advertisement and partner
  assign common = s_reg.advert & line_in.partner_ability;
  assign gig_common_full = s_reg.gig_ctrl[9] & line_in.partner_gig[11];
  assign gig_common_half = s_reg.gig_ctrl[8] & line_in.partner_gig[10];
  assign forced_code = {s_reg.basic_ctrl[pldl_pkg::BC_SPEED_LSB],
                        s_reg.basic_ctrl[pldl_pkg::BC_SPEED_MSB]};

  // next state of everything
  always_comb begin
    s_next = s_reg;
    s_next.rvalid = 1'b0;
    // restart bit self-clears; a fresh write of one still wins
    s_next.basic_ctrl[pldl_pkg::BC_RESTART] = 1'b0;
    s_next.energy_sync = {s_reg.energy_sync[0], line_in.energy};
    s_next.act_sync = {s_reg.act_sync[0], activity};
    wval = writedata[15:0];

    // register writes
    if (write) begin
      if (address == pldl_pkg::ADDR_BASIC_CTRL) begin
        s_next.basic_ctrl = (s_next.basic_ctrl & ~wmask) | (wval & wmask);
        // speed change on the fly drops the link
        if ({s_next.basic_ctrl[6], s_next.basic_ctrl[13]} !=
            {s_reg.basic_ctrl[6], s_reg.basic_ctrl[13]} &&
            s_reg.link_up) begin
          s_next.link_up = 1'b0;
          s_next.state = pldl_pkg::PLDL_DOWN;
        end
      end else if (address == pldl_pkg::ADDR_ADVERT) begin
        s_next.advert = (s_reg.advert & ~wmask) | (wval & wmask);
      end else if (address == pldl_pkg::ADDR_GIG_CTRL) begin
        s_next.gig_ctrl = (s_reg.gig_ctrl & ~wmask) | (wval & wmask);
      end else if (address == pldl_pkg::ADDR_DIAG) begin
        if (wmask[15] && wval[pldl_pkg::DG_START] &&
            s_reg.state != pldl_pkg::PLDL_DIAG) begin
          s_next.diag = {1'b1, 1'b0, wval[13:12], 12'h000};
          s_next.diag_wait = 8'h00;
          s_next.link_up = 1'b0;
          s_next.state = pldl_pkg::PLDL_DIAG;
        end
      end else if (address == pldl_pkg::ADDR_LOOPBACK) begin
        s_next.loopback = (s_reg.loopback & ~wmask) | (wval & wmask);
      end else if (address == pldl_pkg::ADDR_LED_MODE) begin
        if (byteenable[0]) begin
          s_next.led_single = wval[pldl_pkg::LED_MODE_BIT];
        end
      end
    end

    // register reads, unmapped reads return zero
    if (read && !s_reg.rvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = 32'h0000_0000;
      if (address == pldl_pkg::ADDR_BASIC_CTRL) begin
        s_next.rdata[15:0] = s_reg.basic_ctrl;
      end else if (address == pldl_pkg::ADDR_BASIC_STAT) begin
        s_next.rdata[15:0] = {11'h7e4, s_reg.state == pldl_pkg::PLDL_UP,
                              1'b0, s_reg.link_up, 2'h1};
      end else if (address == pldl_pkg::ADDR_ADVERT) begin
        s_next.rdata[15:0] = s_reg.advert;
      end else if (address == pldl_pkg::ADDR_PARTNER) begin
        s_next.rdata[15:0] = s_reg.partner;
      end else if (address == pldl_pkg::ADDR_EXPANSION) begin
        s_next.rdata[15:0] = s_reg.expansion;
      end else if (address == pldl_pkg::ADDR_GIG_CTRL) begin
        s_next.rdata[15:0] = s_reg.gig_ctrl;
      end else if (address == pldl_pkg::ADDR_GIG_STAT) begin
        s_next.rdata[15:0] = s_reg.gig_stat;
      end else if (address == pldl_pkg::ADDR_DIAG) begin
        s_next.rdata[15:0] = s_reg.diag;
      end else if (address == pldl_pkg::ADDR_LOOPBACK) begin
        s_next.rdata[15:0] = s_reg.loopback;
      end else if (address == pldl_pkg::ADDR_LED_MODE) begin
        s_next.rdata[pldl_pkg::LED_MODE_BIT] = s_reg.led_single;
      end else if (address == pldl_pkg::ADDR_LINK_STAT) begin
        s_next.rdata[5:0] = {s_reg.eee_agreed, s_reg.full_duplex,
                             s_reg.speed, s_reg.link_up,
                             loopback_active};
      end else if (address == pldl_pkg::ADDR_ID) begin
        s_next.rdata[15:0] = pldl_pkg::DEVICE_ID;
      end
    end

    // link state machine
    case (s_reg.state)
      pldl_pkg::PLDL_DOWN: begin
        s_next.link_up = 1'b0;
        if (s_reg.energy_sync[1]) begin
          s_next.state = pldl_pkg::PLDL_NEGOT;
        end
      end
      pldl_pkg::PLDL_NEGOT: begin
        if (!s_reg.energy_sync[1]) begin
          s_next.state = pldl_pkg::PLDL_DOWN;
        end else if (!s_reg.basic_ctrl[pldl_pkg::BC_AN_ENABLE]) begin
          // forced mode; a forced gigabit setting never links
          if (forced_code != 2'b10) begin
            s_next.speed = forced_code == 2'b01 ? pldl_pkg::PLDL_SPD_100 :
                           pldl_pkg::PLDL_SPD_10;
            s_next.full_duplex =
              s_reg.basic_ctrl[pldl_pkg::BC_DUPLEX];
            s_next.link_up = 1'b1;
            s_next.state = pldl_pkg::PLDL_UP;
          end
        end else if (!line_in.partner_an) begin
          // parallel detection, never gigabit
          if (line_in.sensed_speed != pldl_pkg::PLDL_SPD_1000) begin
            s_next.speed = line_in.sensed_speed;
            s_next.full_duplex = 1'b0;
            s_next.link_up = 1'b1;
            s_next.expansion = 16'h0000;
            s_next.state = pldl_pkg::PLDL_UP;
          end
        end else if (line_in.role_resolved || line_in.role_fault) begin
          // role first, then highest common mode
          s_next.link_up = 1'b1;
          s_next.state = pldl_pkg::PLDL_UP;
          if (gig_common_full && !line_in.role_fault) begin
            s_next.speed = pldl_pkg::PLDL_SPD_1000;
            s_next.full_duplex = 1'b1;
          end else if (gig_common_half && !line_in.role_fault) begin
            s_next.speed = pldl_pkg::PLDL_SPD_1000;
            s_next.full_duplex = 1'b0;
          end else if (common[8]) begin
            s_next.speed = pldl_pkg::PLDL_SPD_100;
            s_next.full_duplex = 1'b1;
          end else if (common[7]) begin
            s_next.speed = pldl_pkg::PLDL_SPD_100;
            s_next.full_duplex = 1'b0;
          end else if (common[6]) begin
            s_next.speed = pldl_pkg::PLDL_SPD_10;
            s_next.full_duplex = 1'b1;
          end else if (common[5]) begin
            s_next.speed = pldl_pkg::PLDL_SPD_10;
            s_next.full_duplex = 1'b0;
          end else begin
            s_next.link_up = 1'b0;
            s_next.state = pldl_pkg::PLDL_NEGOT;
          end
          // completion records partner abilities
          s_next.partner = line_in.partner_ability;
          s_next.expansion = 16'h0001;
          s_next.gig_stat = {line_in.role_fault, 1'b0,
                             line_in.partner_gig[13:0]};
          s_next.eee_agreed = line_in.partner_eee;
        end
      end
      pldl_pkg::PLDL_UP: begin
        // duplex and pause changes wait for restart or relink
        if (!s_reg.energy_sync[1]) begin
          s_next.link_up = 1'b0;
          s_next.state = pldl_pkg::PLDL_DOWN;
        end else if (s_reg.basic_ctrl[pldl_pkg::BC_RESTART]) begin
          s_next.link_up = 1'b0;
          s_next.state = pldl_pkg::PLDL_NEGOT;
        end
      end
      pldl_pkg::PLDL_DIAG: begin
        s_next.diag_wait = s_reg.diag_wait + 8'h01;
        if (s_reg.diag_wait ==
            8'(pldl_pkg::DIAG_SETTLE_CYCLES) && !line_in.partner_quiet) begin
          // partner still talking, skip the measurement
          s_next.diag[15] = 1'b0;
          s_next.diag[9:8] = pldl_pkg::DIAG_INVALID;
          s_next.diag[7:0] = 8'h00;
          s_next.state = pldl_pkg::PLDL_DOWN;
        end else if (s_reg.diag_wait >=
                     8'(pldl_pkg::DIAG_SETTLE_CYCLES) &&
                     line_in.echo_valid) begin
          s_next.diag[15] = 1'b0;
          s_next.diag[9:8] = line_in.echo_kind == pldl_pkg::DIAG_INVALID ?
                             pldl_pkg::DIAG_NORMAL :
                             line_in.echo_kind;
          s_next.diag[7:0] = line_in.echo_kind == pldl_pkg::DIAG_OPEN ||
                             line_in.echo_kind == pldl_pkg::DIAG_SHORT ?
                             line_in.echo_count : 8'h00;
          s_next.state = pldl_pkg::PLDL_DOWN;
        end else if (s_reg.diag_wait == 8'hff) begin
          s_next.diag_wait = s_reg.diag_wait;
        end
      end
      default: begin
        s_next.state = pldl_pkg::PLDL_DOWN;
      end
    endcase

    // slow blink divider, free-running; blink toggles while traffic persists
    if (s_reg.act_sync[1]) begin
      s_next.act_seen = 1'b1;
    end
    if (s_reg.blink_cnt >= 32'(BLINK_COUNT - 1)) begin
      s_next.blink_cnt = 32'h0000_0000;
      s_next.blink = s_reg.act_seen ? ~s_reg.blink : 1'b0;
      s_next.act_seen = s_reg.act_sync[1];
    end else begin
      s_next.blink_cnt = s_reg.blink_cnt + 32'h0000_0001;
    end

    // led pins, active low
    s_next.link_led_n = 1'b1;
    s_next.act_led_n = 1'b1;
    if (s_reg.link_up) begin
      if (s_reg.led_single) begin
        s_next.link_led_n = 1'b0;
        s_next.act_led_n = ~s_reg.blink;
      end else if (s_reg.speed == pldl_pkg::PLDL_SPD_1000) begin
        s_next.link_led_n = s_reg.blink;
      end else if (s_reg.speed == pldl_pkg::PLDL_SPD_100) begin
        s_next.act_led_n = s_reg.blink;
      end else begin
        s_next.link_led_n = s_reg.blink;
        s_next.act_led_n = s_reg.blink;
      end
    end
  end

  // register the whole state
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_reg <= '0;
      s_reg.basic_ctrl <= pldl_pkg::BASIC_CTRL_RST;
      s_reg.advert <= pldl_pkg::ADVERT_RST;
      s_reg.gig_ctrl <= pldl_pkg::GIG_CTRL_RST;
      s_reg.led_single <= 1'b0;
      s_reg.state <= pldl_pkg::PLDL_DOWN;
      s_reg.link_led_n <= 1'b1;
      s_reg.act_led_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : pldl_port_ctrl

// ==== shared/pldl_pkg.sv ====
// package for the phy link, diagnostic and led control block
// Summary of operation
// - pick best shared mode, 1000 full first
// - parallel detect takes sensed speed, half duplex
// - gigabit only via negotiation, role resolved first
// - negotiation on at reset, bit 12 controls
// - forced speed bits 6,13; duplex bit 8
// - speed change drops link, renegotiates
// - duplex/pause apply on restart or relink
// - completion updates status and partner registers
// - next page agrees energy efficient mode
// - bit 15 starts cable test, self-clears
// - status 00 normal 01 open 10 short 11 invalid
// - invalid when partner not silenced, no measurement
// - eight-bit count, distance 0.8*(count-22)
// - pair select bits 13:12 with start
// - remote loopback returns line data, full duplex; line_tx_data echoes in any duplex, only loopback_active needs full duplex
// - led mode bit, one single, zero tri-colour
// - led pins active low
// - single mode link low, activity toggles
// - tri-colour pins by speed, toggle on activity
package pldl_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_BASIC_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BASIC_STAT = 8'h04;
  localparam logic [7:0] ADDR_ADVERT = 8'h10;
  localparam logic [7:0] ADDR_PARTNER = 8'h14;
  localparam logic [7:0] ADDR_EXPANSION = 8'h18;
  localparam logic [7:0] ADDR_GIG_CTRL = 8'h24;
  localparam logic [7:0] ADDR_GIG_STAT = 8'h28;
  localparam logic [7:0] ADDR_DIAG = 8'h48;
  localparam logic [7:0] ADDR_LOOPBACK = 8'h4c;
  localparam logic [7:0] ADDR_LED_MODE = 8'h50;
  localparam logic [7:0] ADDR_LINK_STAT = 8'h54;
  localparam logic [7:0] ADDR_ID = 8'h58;
  // basic control field positions
  localparam int BC_SPEED_LSB = 6;
  localparam int BC_DUPLEX = 8;
  localparam int BC_RESTART = 9;
  localparam int BC_AN_ENABLE = 12;
  localparam int BC_SPEED_MSB = 13;
  // diagnostic, loopback and led mode field positions
  localparam int DG_START = 15;
  localparam int DG_PAIR_LSB = 12;
  localparam int DG_STAT_LSB = 8;
  localparam int LB_ENABLE = 8;
  localparam int LED_MODE_BIT = 4;
  // reset values
  localparam logic [15:0] BASIC_CTRL_RST = 16'h1340;
  localparam logic [15:0] ADVERT_RST = 16'h01e1;
  localparam logic [15:0] GIG_CTRL_RST = 16'h0700;
  localparam logic [15:0] DEVICE_ID = 16'h5a5a; // arbitrary value
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int BLINK_MS = 100;
  localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;
  localparam int DIAG_SETTLE_CYCLES = 64;
  // cable test status codes
  localparam logic [1:0] DIAG_NORMAL = 2'h0;
  localparam logic [1:0] DIAG_OPEN = 2'h1;
  localparam logic [1:0] DIAG_SHORT = 2'h2;
  localparam logic [1:0] DIAG_INVALID = 2'h3;
  // speed codes
  typedef enum logic [1:0] {
    PLDL_SPD_10 = 2'h0,
    PLDL_SPD_100 = 2'h1,
    PLDL_SPD_1000 = 2'h2
  } pldl_speed_t;
  // link state machine, one-hot
  typedef enum logic [3:0] {
    PLDL_DOWN = 4'b0001,
    PLDL_NEGOT = 4'b0010,
    PLDL_UP = 4'b0100,
    PLDL_DIAG = 4'b1000
  } pldl_state_t;
  // line side status from the analog front end
  typedef struct packed {
    logic energy;          // signal present on the line
    logic partner_an;      // partner sends negotiation pages
    logic [15:0] partner_ability;
    logic [15:0] partner_gig;
    logic partner_eee;     // partner next page offers energy mode
    logic role_resolved;   // master/slave resolved
    logic role_fault;
    pldl_speed_t sensed_speed;
    logic partner_quiet;   // partner silenced for cable test
    logic echo_valid;
    logic [1:0] echo_kind;
    logic [7:0] echo_count;
  } pldl_line_t;
  typedef struct packed {
    logic [15:0] basic_ctrl;
    logic [15:0] advert;
    logic [15:0] gig_ctrl;
    logic [15:0] partner;
    logic [15:0] expansion;
    logic [15:0] gig_stat;
    logic [15:0] diag;
    logic [15:0] loopback;
    logic led_single;
    pldl_state_t state;
    logic link_up;
    logic full_duplex;
    pldl_speed_t speed;
    logic eee_agreed;
    logic [1:0] last_speed_code;
    logic [7:0] diag_wait;
    logic [31:0] rdata;
    logic rvalid;
    logic [31:0] blink_cnt;
    logic blink;
    logic act_seen;
    logic [1:0] energy_sync;
    logic [1:0] act_sync;
    logic link_led_n;
    logic act_led_n;
  } pldl_state_reg_t;
endpackage : pldl_pkg

// ==== test/pldl_port_ctrl_props.sv ====
// port-level checker for the port control block
module pldl_port_ctrl_props #(
  parameter int BLINK_COUNT = 8
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic waitrequest,
  input wire logic [7:0] line_rx_data,
  input wire logic [7:0] line_tx_data,
  input wire logic loopback_active,
  input wire logic probe_start,
  input wire logic [1:0] probe_pair,
  input wire logic link_up,
  input wire logic [1:0] link_speed,
  input wire logic link_indicator_pin,
  input wire logic activity_indicator_pin
);
  logic led_single_reg;
  logic [1:0] pair_reg;
  logic [1:0] spd_reg;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // mirror of fields software wrote; start writes ignored mid-test
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      led_single_reg <= 1'b0;
      pair_reg <= 2'h0;
      spd_reg <= 2'h1;
    end else if (write) begin
      if (address == pldl_pkg::ADDR_LED_MODE)
        led_single_reg <= writedata[pldl_pkg::LED_MODE_BIT];
      if (address == pldl_pkg::ADDR_DIAG && writedata[15] && !probe_start)
        pair_reg <= writedata[13:12];
      if (address == pldl_pkg::ADDR_BASIC_CTRL)
        spd_reg <= {writedata[13], writedata[6]};
    end
  end
  a_write_no_wait: assert property (write |-> !waitrequest)
    else $error("write was stalled");
  a_read_one_wait: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
    else $error("read answer not after one wait cycle");
  a_dark_no_link: assert property (
    !link_up [*3] |-> link_indicator_pin && activity_indicator_pin)
    else $error("led lit without link");
  a_loop_echo: assert property (
    loopback_active |-> line_tx_data == line_rx_data)
    else $error("loopback data differs");
  a_single_link_lit: assert property (
    (led_single_reg && link_up) [*3] |-> !link_indicator_pin)
    else $error("single mode link led dark");
  a_tri_gig_dark: assert property (
    (!led_single_reg && link_up && link_speed == 2'h2) [*3]
    |-> activity_indicator_pin)
    else $error("gigabit lit the activity led");
  a_probe_pair_sel: assert property (
    probe_start |-> probe_pair == pair_reg)
    else $error("probe pair not the one written");
  a_probe_ends: assert property (
    $rose(probe_start) |-> ##[1:400] !probe_start)
    else $error("cable test never completed");
  a_speed_drop: assert property (
    write && address == pldl_pkg::ADDR_BASIC_CTRL && link_up
    && {writedata[13], writedata[6]} != spd_reg |-> ##[1:4] !link_up)
    else $error("speed change kept the link");
  c_gig_up: cover property (link_up && link_speed == 2'h2);
  c_probe: cover property ($rose(probe_start));
  c_loop: cover property (loopback_active);
endmodule : pldl_port_ctrl_props

bind pldl_port_ctrl pldl_port_ctrl_props #(.BLINK_COUNT(BLINK_COUNT)) u_props (
  .clock(clock), .reset_n(reset_n), .address(address), .read(read),
  .write(write), .writedata(writedata), .waitrequest(waitrequest),
  .line_rx_data(line_rx_data), .line_tx_data(line_tx_data),
  .loopback_active(loopback_active), .probe_start(probe_start),
  .probe_pair(probe_pair), .link_up(link_up), .link_speed(link_speed),
  .link_indicator_pin(link_indicator_pin),
  .activity_indicator_pin(activity_indicator_pin));

// ==== test/pldl_link_partner.sv ====
// link partner model on the cable side of one port
module pldl_link_partner (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic an_on,
  input wire logic [15:0] ability,
  input wire logic [15:0] gig,
  input wire logic [1:0] sensed,
  input wire logic quiet_ok,
  input wire logic [1:0] fault_kind,
  input wire logic [7:0] fault_count,
  input wire logic probe_start,
  output pldl_pkg::pldl_line_t line_out,
  output logic [7:0] rx_data
);
  logic [7:0] echo_cnt;
  // rx pattern moves every cycle; echo delay counts the probe time
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rx_data <= 8'h00;
      echo_cnt <= 8'h00;
    end else begin
      rx_data <= rx_data + 8'h35;
      if (probe_start && quiet_ok && echo_cnt != 8'hff)
        echo_cnt <= echo_cnt + 8'h01;
      else if (!probe_start)
        echo_cnt <= 8'h00;
    end
  end
  // front end status as seen from this partner
  always_comb begin
    line_out = '0;
    line_out.energy = !(probe_start && quiet_ok);
    line_out.partner_an = an_on;
    line_out.partner_ability = ability;
    line_out.partner_gig = gig;
    line_out.partner_eee = an_on;
    line_out.role_resolved = an_on;
    line_out.sensed_speed = pldl_pkg::pldl_speed_t'(sensed);
    line_out.partner_quiet = probe_start && quiet_ok;
    line_out.echo_valid = echo_cnt > 8'h48; // only after settle time
    line_out.echo_kind = fault_kind;
    line_out.echo_count = fault_count;
  end
endmodule : pldl_link_partner

// ==== test/tb_top.sv ====
// self-checking bench for the port control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [15:0] value; logic [15:0] mask;} pldl_note_t;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  // partner pages carry no ability at first, so the link stays down
  logic waitrequest, activity = 1'b0, an_on = 1'b1, quiet_ok = 1'b0;
  logic [15:0] ability = 16'h0000, gig = 16'h0000;
  logic [1:0] sensed = 2'h0, kind = 2'h0, probe_pair, link_speed;
  logic [7:0] count = 8'h00, rx_data, tx_data;
  logic probe_start, link_up, fdx, loop_on, link_pin, act_pin;
  pldl_pkg::pldl_line_t line_in;
  pldl_note_t notes[$], note;
  int fails = 0, n_compared = 0;
  pldl_port_ctrl #(.BLINK_COUNT(8)) dut (.clock(clock), .reset_n(reset_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
    .line_in(line_in), .activity(activity), .line_rx_data(rx_data),
    .line_tx_data(tx_data), .loopback_active(loop_on),
    .probe_start(probe_start), .probe_pair(probe_pair), .link_up(link_up),
    .link_speed(link_speed), .link_full_duplex(fdx),
    .link_indicator_pin(link_pin), .activity_indicator_pin(act_pin));
  pldl_link_partner partner (.clock(clock), .reset_n(reset_n),
    .an_on(an_on), .ability(ability), .gig(gig), .sensed(sensed),
    .quiet_ok(quiet_ok), .fault_kind(kind), .fault_count(count),
    .probe_start(probe_start), .line_out(line_in), .rx_data(rx_data));
  // clock
  always #5 clock = ~clock;
  task automatic compare(input string what, input logic [15:0] e,
                         input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : compare
  task automatic finish_test();
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  // read results against the oldest note
  always @(posedge clock) begin
    if (read && waitrequest === 1'b0 && notes.size() > 0) begin
      note = notes.pop_front();
      if (note.mask != 16'h0000)
        compare("readdata", note.value & note.mask, readdata[15:0] & note.mask);
    end
  end
  // avalon master: hold until waitrequest low, then release
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
                     input logic [15:0] m, output logic [15:0] q);
    address <= a;
    writedata <= {16'h0000, d};
    write <= wr;
    read <= !wr;
    if (!wr) notes.push_back('{d, m});
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    q = readdata[15:0];
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, 16'h0000, q);
  endtask : wr
  task automatic peer(input logic a, input logic [15:0] ab,
                      input logic [15:0] g, input logic [1:0] s);
    an_on <= a;
    ability <= ab;
    gig <= g;
    sensed <= s;
  endtask : peer
  task automatic wait_link(input logic [1:0] s, input logic d);
    int n;
    n = 0;
    while (!(link_up === 1'b1 && link_speed === s) && n < 3000) begin
      @(posedge clock);
      n++;
    end
    compare("link", {12'h001, s, 1'b0, d}, {11'h000, link_up, link_speed,
      1'b0, fdx});
  endtask : wait_link
  task automatic leds(input logic [1:0] e);
    repeat (4) @(posedge clock);
    compare("leds", {14'h0000, e}, {14'h0000, link_pin, act_pin});
  endtask : leds
  // start a cable test, poll the start bit, then check the result
  task automatic probe(input logic [1:0] p, input logic [15:0] e,
                       input logic [15:0] m);
    logic [15:0] q;
    int n;
    n = 0;
    wr(pldl_pkg::ADDR_DIAG, {2'b10, p, 12'h000});
    do begin
      bus(1'b0, pldl_pkg::ADDR_DIAG, 16'h0000, 16'h0000, q);
      n++;
    end while (q[15] !== 1'b0 && n < 200);
    bus(1'b0, pldl_pkg::ADDR_DIAG, e, m, q);
  endtask : probe
  // watchdog
  initial begin
    #200_000;
    fails++;
    finish_test();
  end
  // main sequence
  initial begin
    logic [7:0] ra [6] = '{pldl_pkg::ADDR_BASIC_CTRL, pldl_pkg::ADDR_ADVERT,
      pldl_pkg::ADDR_GIG_CTRL, pldl_pkg::ADDR_ID, pldl_pkg::ADDR_LED_MODE,
      8'h3c};
    logic [15:0] rv [6] = '{pldl_pkg::BASIC_CTRL_RST & 16'hfdff,
      pldl_pkg::ADVERT_RST,
      pldl_pkg::GIG_CTRL_RST, pldl_pkg::DEVICE_ID, 16'h0000, 16'h0000};
    logic [15:0] q;
    logic [1:0] pr;
    logic pv;
    int t;
    void'($urandom(32'h31e5403c));
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    leds(2'h3);
    foreach (ra[i]) bus(1'b0, ra[i], rv[i], 16'hffff, q);
    peer(1'b1, 16'h01e1, 16'h0f00, 2'h2);
    wait_link(2'h2, 1'b1);
    bus(1'b0, pldl_pkg::ADDR_PARTNER, 16'h01e1, 16'hffff, q);
    bus(1'b0, pldl_pkg::ADDR_BASIC_STAT, 16'h0004, 16'h0004, q);
    bus(1'b0, pldl_pkg::ADDR_GIG_STAT, 16'h0f00, 16'hffff, q);
    bus(1'b0, pldl_pkg::ADDR_LINK_STAT, 16'h003a, 16'h003f, q);
    leds(2'h1);
    peer(1'b1, 16'h0081, 16'h0000, 2'h1);
    repeat (30) @(posedge clock);
    compare("held_speed", 16'h0002, {14'h0000, link_speed});
    wr(pldl_pkg::ADDR_BASIC_CTRL, 16'h1340);
    wait_link(2'h1, 1'b0);
    wr(pldl_pkg::ADDR_BASIC_CTRL, 16'h0100);
    wait_link(2'h0, 1'b1);
    leds(2'h0);
    wr(pldl_pkg::ADDR_BASIC_CTRL, 16'h2100);
    wait_link(2'h1, 1'b1);
    wr(pldl_pkg::ADDR_LED_MODE, 16'h0010);
    leds(2'h1);
    activity <= 1'b1;
    t = 0;
    repeat (80) begin
      pv = act_pin;
      @(posedge clock);
      if (act_pin !== pv) t++;
    end
    compare("blink", 16'h0001, {15'h0000, t > 2});
    activity <= 1'b0;
    repeat (40) @(posedge clock);
    compare("act_idle", 16'h0001, {15'h0000, act_pin});
    wr(pldl_pkg::ADDR_LED_MODE, 16'h0000);
    peer(1'b0, 16'h0000, 16'h0000, 2'h0);
    wr(pldl_pkg::ADDR_BASIC_CTRL, 16'h1340);
    wait_link(2'h0, 1'b0);
    wr(pldl_pkg::ADDR_BASIC_CTRL, 16'h0140);
    wr(pldl_pkg::ADDR_GIG_CTRL, 16'h1000);
    probe(2'h0, 16'h0300, 16'hb300);
    quiet_ok <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      pr = 2'(k + 1);
      kind <= 2'(k);
      count <= 8'($urandom);
      @(posedge clock);
      probe(pr, {2'b00, pr, 2'b00, kind, count},
            k == 0 ? 16'hb300 : 16'hb3ff);
    end
    compare("forced_gig", 16'h0000, {15'h0000, link_up});
    wr(pldl_pkg::ADDR_GIG_CTRL, 16'h0700);
    wr(pldl_pkg::ADDR_BASIC_CTRL, 16'h1340);
    peer(1'b1, 16'h01e1, 16'h0f00, 2'h2);
    wr(pldl_pkg::ADDR_ADVERT, 16'h0181);
    wr(pldl_pkg::ADDR_GIG_CTRL, 16'h0c00);
    wr(pldl_pkg::ADDR_LOOPBACK, 16'h01f0);
    wr(pldl_pkg::ADDR_BASIC_CTRL, 16'h3300);
    wait_link(2'h1, 1'b1);
    compare("loop_on", 16'h0001, {15'h0000, loop_on});
    compare("line_tx", {8'h00, rx_data}, {8'h00, tx_data});
    wr(pldl_pkg::ADDR_GIG_CTRL, 16'h1f00);
    wr(pldl_pkg::ADDR_BASIC_CTRL, 16'h1340);
    wait_link(2'h2, 1'b1);
    compare("loop_gig", 16'h0001, {15'h0000, loop_on});
    finish_test();
  end
endmodule : tb_top
